// File: hdl/hpb_host_port.sv
// Host access port: parallel and serial word transfers, interrupt acknowledge
// Behaviour
// [R1] Host accesses are taken only while the active-low chip enable is low.
// [R2] Serial host drives chip enable from its slave select.
// [R3] Serial, byte order low: low byte goes before high byte.
// [R4] Serial, byte order high: high byte goes before low byte.
// [R5] Parallel byte order follows byte order pin, lane bit and width pin.
// [R6] Acknowledge inputs act only when level interrupt select is set.
// [R7] Level mode: a general interrupt drives its output low.
// [R8] General acknowledge high for 60 ns returns general output high.
// [R9] Message acknowledge high for 60 ns returns message output high.
// [R10] Reading the pending interrupt register clears asserted level outputs.
// [R11] Data bus is driven only during host reads.
// [R12] Every access moves a full 16-bit word.
// [R13] 8-bit mode uses lines 7:0, two byte operations per word.
// [R14] 8-bit mode: byte order pin picks low-first or high-first.
// [R15] 16-bit mode ignores the lane address bit.
// [R16] 8-bit mode: lane bit selects byte, polarity from byte order pin.
// [R17] Width pin high selects 16-bit, low selects 8-bit.
// [R18] Combined acknowledge variant replaces both acknowledge inputs.
// [R19] Host keeps write control or chip enable high on address changes.
// [R20] Ready held low during initialisation or test; no access then.
// [R21] 8-bit writes commit only after both bytes arrive.
`timescale 1ns/1ns
`default_nettype none

module hpb_host_port
  import hpb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        chip_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        read_enable_n,
  input  wire logic [14:0] host_word_address,
  input  wire logic        byte_lane_select,
  input  wire logic [15:0] host_data_in,
  output var  logic [15:0] host_data_out,
  output var  logic        host_data_lo_oe_n,
  output var  logic        host_data_hi_oe_n,
  input  wire logic        byte_order_select,
  input  wire logic        bus_width_select,
  input  wire logic        serial_variant,
  input  wire logic        spi_sck,
  input  wire logic        spi_si,
  output var  logic        spi_so,
  output var  logic        spi_so_oe_n,
  input  wire logic        combined_ack_variant,
  input  wire logic        general_irq_ack,
  input  wire logic        message_irq_ack,
  input  wire logic        combined_irq_ack,
  input  wire logic        level_irq_select,
  input  wire logic        general_irq_event,
  input  wire logic        message_irq_event,
  output var  logic        general_irq_n,
  output var  logic        message_irq_n,
  input  wire logic        init_busy,
  output var  logic        host_ready,
  output var  logic        mem_req,
  output var  logic        mem_we,
  output var  logic [14:0] mem_addr,
  output var  logic [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic lane_hi(input logic a0, input logic bos);
    lane_hi = a0 ^ bos;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              sck3_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      sck3_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= {chip_enable_n, write_enable_n, read_enable_n, host_word_address, byte_lane_select,
                  host_data_in, byte_order_select, bus_width_select, serial_variant,
                  combined_ack_variant, general_irq_ack, message_irq_ack, combined_irq_ack,
                  spi_sck, spi_si};
      sync2_q <= sync1_q;
      sck3_q  <= sync2_q[1];
    end
  end

  logic        s_ce_n;
  logic        s_we_n;
  logic        s_oe_n;
  logic [14:0] s_addr;
  logic        s_a0;
  logic [15:0] s_data;
  logic        s_bos;
  logic        s_bw16;
  logic        s_serial;
  logic        s_comb;
  logic [2:0]  s_ack;
  logic        s_sck;
  logic        s_si;

  assign {s_ce_n, s_we_n, s_oe_n, s_addr, s_a0, s_data, s_bos, s_bw16, s_serial,
          s_comb, s_ack, s_sck, s_si} = sync2_q;

  // ----------------------------------------
  // Ready
  // ----------------------------------------
  logic ready_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ready_q <= 1'b0;
    else
      ready_q <= ~init_busy; // [R20]
  end

  // ----------------------------------------
  // Request mux and read return
  // ----------------------------------------
  logic        par_req;
  logic        par_we;
  logic [14:0] par_addr;
  logic [15:0] par_wd;
  logic        spi_req;
  logic        spi_we;
  logic [14:0] spi_addr;
  logic [15:0] spi_wd;
  logic        req_c;
  logic        we_c;
  logic [14:0] addr_c;
  logic        rd_pend_q;
  logic        ret_q;
  logic [15:0] rdata_q;
  logic        pend_rd_q;

  assign req_c  = s_serial ? spi_req : par_req;
  assign we_c   = s_serial ? spi_we : par_we;
  assign addr_c = s_serial ? spi_addr : par_addr;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= ADDR_RST;
      mem_wdata <= WORD_RST;
      rd_pend_q <= 1'b0;
      ret_q     <= 1'b0;
      rdata_q   <= WORD_RST;
      pend_rd_q <= 1'b0;
    end
    else
    begin
      mem_req   <= req_c;
      mem_we    <= req_c & we_c;
      mem_addr  <= addr_c;
      mem_wdata <= s_serial ? spi_wd : par_wd; // [R12]
      rd_pend_q <= req_c & ~we_c;
      ret_q     <= rd_pend_q;
      pend_rd_q <= req_c & ~we_c & (addr_c == PENDING_IRQ_WADDR);
      if (rd_pend_q)
        rdata_q <= mem_rdata;
    end
  end

  // ----------------------------------------
  // Parallel port
  // ----------------------------------------
  logic        rd_act;
  logic        wr_act;
  logic        rd_act_q;
  logic        wr_act_q;
  logic        wr_end;
  logic [15:0] wlat_q;
  logic [14:0] walat_q;
  logic        wa0_q;
  logic        w_hi;
  logic [1:0]  got_q;
  logic [1:0]  got_new;
  logic [14:0] hold_addr_q;
  logic [15:0] hold_q;
  logic        same_word;
  logic        par_rvld_q;

  assign rd_act    = ~s_ce_n & ~s_oe_n & ~s_serial & ready_q; // [R1] [R20]
  assign wr_act    = ~s_ce_n & ~s_we_n & ~s_serial & ready_q; // [R1] [R19]
  assign wr_end    = wr_act_q & ~wr_act;
  assign w_hi      = lane_hi(wa0_q, s_bos); // [R5] [R16]
  assign same_word = (walat_q == hold_addr_q);
  assign got_new   = (same_word ? got_q : 2'h0) | (w_hi ? 2'h2 : 2'h1);

  always_comb
  begin
    par_req  = 1'b0;
    par_we   = 1'b0;
    par_addr = walat_q; // [R15]
    par_wd   = wlat_q;
    if (rd_act & ~rd_act_q)
    begin
      par_req  = 1'b1;
      par_addr = s_addr;
    end
    else if (wr_end & s_bw16) // [R17]
    begin
      par_req = 1'b1;
      par_we  = 1'b1;
    end
    else if (wr_end & (got_new == 2'h3)) // [R21] [R13]
    begin
      par_req = 1'b1;
      par_we  = 1'b1;
      par_wd  = w_hi ? {wlat_q[7:0], hold_q[7:0]} : {hold_q[15:8], wlat_q[7:0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_act_q    <= 1'b0;
      wr_act_q    <= 1'b0;
      wlat_q      <= WORD_RST;
      walat_q     <= ADDR_RST;
      wa0_q       <= 1'b0;
      got_q       <= 2'h0;
      hold_addr_q <= ADDR_RST;
      hold_q      <= WORD_RST;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act)
      begin
        wlat_q  <= s_data;
        walat_q <= s_addr;
        wa0_q   <= s_a0;
      end
      if (wr_end & ~s_bw16)
      begin
        hold_addr_q <= walat_q;
        got_q       <= (got_new == 2'h3) ? 2'h0 : got_new; // [R21]
        if (w_hi)
          hold_q[15:8] <= wlat_q[7:0];
        else
          hold_q[7:0] <= wlat_q[7:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      par_rvld_q        <= 1'b0;
      host_data_out     <= WORD_RST;
      host_data_lo_oe_n <= 1'b1;
      host_data_hi_oe_n <= 1'b1;
    end
    else
    begin
      if (!rd_act)
        par_rvld_q <= 1'b0;
      else if (ret_q)
        par_rvld_q <= 1'b1;
      host_data_lo_oe_n <= ~(rd_act & par_rvld_q); // [R11]
      host_data_hi_oe_n <= ~(rd_act & par_rvld_q & s_bw16); // [R13]
      if (s_bw16)
        host_data_out <= rdata_q;
      else
        host_data_out <= {BYTE_RST, pick_byte(rdata_q, lane_hi(s_a0, s_bos))}; // [R14] [R16]
    end
  end

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  hpb_spi_st_t st_q;
  logic        spi_act;
  logic        sck_r;
  logic        sck_f;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_sh_q;
  logic [2:0]  bit_q;
  logic        cmd_rd_q;
  logic [14:0] sp_addr_q;
  logic        ph_q;
  logic [7:0]  wbyte_q;
  logic [7:0]  tx_sh_q;
  logic [7:0]  tx_next_q;

  assign spi_act   = ~s_ce_n & s_serial & ready_q; // [R1] [R2]
  assign sck_r     = s_sck & ~sck3_q;
  assign sck_f     = ~s_sck & sck3_q;
  assign byte_done = spi_act & sck_r & (bit_q == BIT_LAST);
  assign rx_byte   = {rx_sh_q[6:0], s_si};

  always_comb
  begin
    spi_req  = 1'b0;
    spi_we   = 1'b0;
    spi_addr = sp_addr_q;
    spi_wd   = s_bos ? {wbyte_q, rx_byte} : {rx_byte, wbyte_q}; // [R3] [R4]
    if (byte_done)
    begin
      unique case (st_q)
        SP_AL:
        begin
          spi_req  = cmd_rd_q;
          spi_addr = {sp_addr_q[14:8], rx_byte};
        end
        SP_DATA:
        begin
          spi_req = ph_q;
          spi_we  = ~cmd_rd_q;
          if (cmd_rd_q)
            spi_addr = sp_addr_q + 15'h0001;
        end
        default:
        begin
          spi_req = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !spi_act)
    begin
      st_q      <= SP_CMD;
      bit_q     <= BIT_RST;
      rx_sh_q   <= BYTE_RST;
      ph_q      <= 1'b0;
      cmd_rd_q  <= 1'b0;
      sp_addr_q <= rst_n ? sp_addr_q : ADDR_RST;
      wbyte_q   <= BYTE_RST;
    end
    else if (sck_r)
    begin
      rx_sh_q <= rx_byte;
      bit_q   <= bit_q + 3'h1;
      if (byte_done)
      begin
        unique case (st_q)
          SP_CMD:
          begin
            cmd_rd_q <= rx_byte[SPI_CMD_RD_BIT];
            st_q     <= SP_AH;
          end
          SP_AH:
          begin
            sp_addr_q[14:8] <= rx_byte[6:0];
            st_q            <= SP_AL;
          end
          SP_AL:
          begin
            sp_addr_q[7:0] <= rx_byte;
            st_q           <= SP_DATA;
          end
          SP_DATA:
          begin
            ph_q    <= ~ph_q;
            wbyte_q <= rx_byte;
            if (ph_q)
              sp_addr_q <= sp_addr_q + 15'h0001; // [R12]
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_sh_q     <= BYTE_RST;
      tx_next_q   <= BYTE_RST;
      spi_so      <= 1'b0;
      spi_so_oe_n <= 1'b1;
    end
    else
    begin
      spi_so_oe_n <= ~(spi_act & cmd_rd_q & (st_q == SP_DATA)); // [R11]
      if (ret_q & s_serial)
      begin
        tx_sh_q   <= pick_byte(rdata_q, s_bos); // [R3] [R4]
        tx_next_q <= pick_byte(rdata_q, ~s_bos);
      end
      else if (byte_done & (st_q == SP_DATA) & ~ph_q)
        tx_sh_q <= tx_next_q;
      else if (spi_act & sck_f)
      begin
        spi_so  <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Level interrupts and acknowledge
  // ----------------------------------------
  logic [1:0]      ack_raw;
  logic [1:0]      irq_ev;
  logic [1:0]      irq_n_q;
  logic [1:0][4:0] ack_cnt_q;

  assign ack_raw = s_comb ? {2{s_ack[0]}} : {s_ack[1], s_ack[2]}; // [R18]
  assign irq_ev  = {message_irq_event, general_irq_event};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_n_q   <= IRQ_N_RST;
      ack_cnt_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!level_irq_select) // [R6]
        begin
          ack_cnt_q[i] <= 5'h00;
          irq_n_q[i]   <= ~irq_ev[i];
        end
        else
        begin
          if (!ack_raw[i])
            ack_cnt_q[i] <= 5'h00;
          else if (ack_cnt_q[i] != ACK_SAT_CNT)
            ack_cnt_q[i] <= ack_cnt_q[i] + 5'h01;
          if (irq_ev[i])
            irq_n_q[i] <= 1'b0; // [R7]
          else if ((ack_raw[i] & (ack_cnt_q[i] == ACK_LAST_CNT)) | pend_rd_q)
            irq_n_q[i] <= 1'b1; // [R8] [R9] [R10]
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      general_irq_n <= 1'b1;
      message_irq_n <= 1'b1;
      host_ready    <= 1'b0;
    end
    else
    begin
      general_irq_n <= irq_n_q[IRQ_GEN];
      message_irq_n <= irq_n_q[IRQ_MSG];
      host_ready    <= ready_q; // [R20]
    end
  end

endmodule

`default_nettype wire

// File: hdl/hpb_pkg.sv
// Constants and types for the host access port
package hpb_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned ACK_MIN_NS     = 60;
  localparam int unsigned ACK_MIN_CYC    = (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  ACK_LAST_CNT   = 5'(ACK_MIN_CYC - 1);
  localparam logic [4:0]  ACK_SAT_CNT    = 5'(ACK_MIN_CYC);

  // ----------------------------------------
  // Addresses and field positions
  // ----------------------------------------
  localparam logic [14:0] PENDING_IRQ_WADDR = 15'h0006;
  localparam int unsigned SPI_CMD_RD_BIT    = 7;
  localparam int unsigned SYNC_W            = 44;
  localparam int unsigned IRQ_GEN           = 0;
  localparam int unsigned IRQ_MSG           = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RST  = {3'h7, 41'h0};
  localparam logic [14:0] ADDR_RST        = 15'h0000;
  localparam logic [15:0] WORD_RST        = 16'h0000;
  localparam logic [7:0]  BYTE_RST        = 8'h00;
  localparam logic [2:0]  BIT_RST         = 3'h0;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic [1:0]  IRQ_N_RST       = 2'h3;

  // ----------------------------------------
  // Serial frame states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SP_CMD  = 4'h1,
    SP_AH   = 4'h2,
    SP_AL   = 4'h4,
    SP_DATA = 4'h8
  } hpb_spi_st_t;

endpackage

// File: tb/hpb_host_model.sv
// Host processor model driving the parallel port and the serial port
`timescale 1ns/1ns
`default_nettype none
module hpb_host_model (
  input  wire logic        clk,
  input  wire logic        host_ready,
  input  wire logic [15:0] host_data_out,
  input  wire logic        host_data_lo_oe_n,
  input  wire logic        host_data_hi_oe_n,
  input  wire logic        spi_so,
  output var  logic        spi_sck,
  output var  logic        spi_si,
  output var  logic        chip_enable_n,
  output var  logic        write_enable_n,
  output var  logic        read_enable_n,
  output var  logic [14:0] host_word_address,
  output var  logic        byte_lane_select,
  output wire logic [15:0] host_data_in
);
  logic        drv_en = 1'b0;
  logic [15:0] drv_q  = 16'h0000;

  initial
  begin
    chip_enable_n = 1'b1;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    host_word_address = 15'h0000;
    byte_lane_select = 1'b0;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end

  // Wire level from all enables; undriven lines pulled down
  assign host_data_in = drv_en ? drv_q : {host_data_hi_oe_n ? 8'h00 : host_data_out[15:8],
                                          host_data_lo_oe_n ? 8'h00 : host_data_out[7:0]};

  // One access; returns {lo_oe_n, hi_oe_n, bus}
  task automatic access(input logic wr, input logic [14:0] a, input logic lane, input logic [15:0] d,
                        input logic sel, output logic [17:0] r);
    wait (host_ready === 1'b1);
    @(posedge clk);
    #1;
    host_word_address = a;
    byte_lane_select = lane;
    drv_q = d;
    drv_en = wr;
    chip_enable_n = !sel;
    @(posedge clk);
    #1;
    write_enable_n = !wr;
    read_enable_n = wr;
    repeat (10) @(posedge clk);
    #1;
    r = {host_data_lo_oe_n, host_data_hi_oe_n, host_data_in};
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    drv_en = 1'b0;
    @(posedge clk);
    #1;
    chip_enable_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // One serial frame, mode 0, MSB first; SO is sampled at each rising SCK
  task automatic spi_frame(input logic [39:0] f, output logic [39:0] q);
    wait (host_ready === 1'b1);
    @(posedge clk);
    #1 chip_enable_n = 1'b0;
    for (int i = 39; i >= 0; i--)
    begin
      spi_si = f[i];
      repeat (8) @(posedge clk);
      #1 spi_sck = 1'b1;
      q[i] = spi_so;
      repeat (8) @(posedge clk);
      #1 spi_sck = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 chip_enable_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/hpb_host_port_props.sv
// Property checker for the host access port
`timescale 1ns/1ns
`default_nettype none
module hpb_host_port_props
  import hpb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_enable_n,
  input wire logic read_enable_n,
  input wire logic mem_req,
  input wire logic host_data_lo_oe_n,
  input wire logic host_data_hi_oe_n,
  input wire logic bus_width_select,
  input wire logic level_irq_select,
  input wire logic general_irq_event,
  input wire logic general_irq_ack,
  input wire logic message_irq_ack,
  input wire logic combined_irq_ack,
  input wire logic general_irq_n,
  input wire logic message_irq_n,
  input wire logic init_busy,
  input wire logic host_ready
);
  logic [4:0] gen_cnt_q;
  logic [4:0] msg_cnt_q;

  // ------------------------------
  // Acknowledge run length
  // ------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || !general_irq_ack)
      gen_cnt_q <= 5'h00;
    else if (gen_cnt_q != 5'h1f)
      gen_cnt_q <= gen_cnt_q + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !message_irq_ack)
      msg_cnt_q <= 5'h00;
    else if (msg_cnt_q != 5'h1f)
      msg_cnt_q <= msg_cnt_q + 5'h01;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------
  // Properties
  // ------------------------------
  sequence s_gen_quiet;
    (!general_irq_ack && !combined_irq_ack && read_enable_n)[*8];
  endsequence
  sequence s_msg_quiet;
    (!message_irq_ack && !combined_irq_ack && read_enable_n)[*8];
  endsequence

  property p_ce_gate;
    chip_enable_n [*8] |-> !mem_req;
  endproperty
  property p_bus_release;
    (read_enable_n || chip_enable_n) [*6] |-> host_data_lo_oe_n && host_data_hi_oe_n;
  endproperty
  property p_narrow;
    !bus_width_select |-> host_data_hi_oe_n;
  endproperty
  property p_pulse;
    !level_irq_select && !general_irq_event |=> ##1 general_irq_n;
  endproperty
  property p_gen_set;
    level_irq_select && general_irq_event |=> ##1 !general_irq_n;
  endproperty
  property p_gen_ack;
    level_irq_select && gen_cnt_q == 5'h18 |-> general_irq_n;
  endproperty
  property p_gen_hold;
    s_gen_quiet ##0 (level_irq_select && !general_irq_n) |=> !general_irq_n;
  endproperty
  property p_msg_ack;
    level_irq_select && msg_cnt_q == 5'h18 |-> message_irq_n;
  endproperty
  property p_msg_hold;
    s_msg_quiet ##0 (level_irq_select && !message_irq_n) |=> !message_irq_n;
  endproperty
  property p_busy;
    init_busy [*3] |-> !host_ready;
  endproperty

  a_ce_gate: assert property (p_ce_gate) else $error("access taken without chip enable");
  a_bus_release: assert property (p_bus_release) else $error("data bus driven outside read");
  a_narrow: assert property (p_narrow) else $error("upper lines driven in 8-bit mode");
  a_pulse: assert property (p_pulse) else $error("pulse mode output held low");
  a_gen_set: assert property (p_gen_set) else $error("general output not set");
  a_gen_ack: assert property (p_gen_ack) else $error("general ack did not clear");
  a_gen_hold: assert property (p_gen_hold) else $error("general output cleared early");
  a_msg_ack: assert property (p_msg_ack) else $error("message ack did not clear");
  a_msg_hold: assert property (p_msg_hold) else $error("message output cleared early");
  a_busy: assert property (p_busy) else $error("ready high while busy");
endmodule

bind hpb_host_port hpb_host_port_props u_props (
  .clk, .rst_n, .chip_enable_n, .read_enable_n, .mem_req, .host_data_lo_oe_n, .host_data_hi_oe_n,
  .bus_width_select, .level_irq_select, .general_irq_event, .general_irq_ack, .message_irq_ack,
  .combined_irq_ack, .general_irq_n, .message_irq_n, .init_busy, .host_ready
);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the host access port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import hpb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, init_busy = 1'b1;
  logic chip_enable_n, write_enable_n, read_enable_n, byte_lane_select;
  logic [14:0] host_word_address, mem_addr;
  logic [15:0] host_data_in, host_data_out, mem_wdata, mem_rdata;
  logic host_data_lo_oe_n, host_data_hi_oe_n, host_ready, mem_req, mem_we;
  logic byte_order_select = 1'b0, bus_width_select = 1'b1, combined_ack_variant = 1'b0;
  logic general_irq_ack = 1'b0, message_irq_ack = 1'b0, combined_irq_ack = 1'b0;
  logic level_irq_select = 1'b1, general_irq_event = 1'b0, message_irq_event = 1'b0;
  logic general_irq_n, message_irq_n;
  logic serial_variant = 1'b0, spi_sck, spi_si, spi_so, spi_so_oe_n;
  logic [31:0] last;
  logic [17:0] r;
  int n_req = 0, miscompares = 0, n_checks = 0;

  always #2 clk = ~clk;
  assign mem_rdata = {~mem_addr[7:0], mem_addr[7:0]};

  hpb_host_port DUT (
    .clk, .rst_n, .chip_enable_n, .write_enable_n, .read_enable_n, .host_word_address,
    .byte_lane_select, .host_data_in, .host_data_out, .host_data_lo_oe_n, .host_data_hi_oe_n,
    .byte_order_select, .bus_width_select, .serial_variant, .spi_sck, .spi_si,
    .spi_so, .spi_so_oe_n, .combined_ack_variant, .general_irq_ack, .message_irq_ack,
    .combined_irq_ack, .level_irq_select, .general_irq_event, .message_irq_event, .general_irq_n,
    .message_irq_n, .init_busy, .host_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata
  );

  hpb_host_model host (
    .clk, .host_ready, .host_data_out, .host_data_lo_oe_n, .host_data_hi_oe_n, .spi_so, .spi_sck,
    .spi_si, .chip_enable_n,
    .write_enable_n, .read_enable_n, .host_word_address, .byte_lane_select, .host_data_in
  );

  always @(posedge clk)
  begin
    if (mem_req === 1'b1)
    begin
      n_req++;
      last = {mem_we, mem_addr, mem_wdata};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic pulse(input logic [1:0] w);
    @(posedge clk);
    #1 {message_irq_event, general_irq_event} = w;
    @(posedge clk);
    #1 {message_irq_event, general_irq_event} = 2'b00;
    @(posedge clk);
    #1;
  endtask

  task automatic ack(input logic [2:0] w, input int n);
    {combined_irq_ack, message_irq_ack, general_irq_ack} = w;
    repeat (n) @(posedge clk);
    #1 {combined_irq_ack, message_irq_ack, general_irq_ack} = 3'b000;
    repeat (10) @(posedge clk);
    #1;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_ready;
    repeat (6) @(posedge clk);
    #1 chk(host_ready, 1'b0, "ready while busy");
    init_busy = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(host_ready, 1'b1, "ready after busy");
    $display("done: ready");
  endtask

  task automatic t_word16;
    bus_width_select = 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      byte_order_select = o[0];
      n_req = 0;
      host.access(1'b1, 15'h0123, 1'b1, 16'hbeef, 1'b1, r);
      chk(n_req, 1, "one commit per word");
      chk(last, {1'b1, 15'h0123, 16'hbeef}, "word write");
      host.access(1'b0, 15'h0042, 1'b1, 16'h0000, 1'b1, r);
      chk(r, {2'b00, 16'hbd42}, "word read");
    end
    $display("done: word16");
  endtask

  task automatic t_byte8;
    bus_width_select = 1'b0;
    for (int o = 0; o < 2; o++)
    begin
      byte_order_select = o[0];
      n_req = 0;
      host.access(1'b1, 15'h0200, ~o[0], 16'h00a5, 1'b1, r);
      chk(n_req, 0, "first byte held");
      host.access(1'b1, 15'h0200, o[0], 16'h005a, 1'b1, r);
      chk(n_req, 1, "pair committed");
      chk(last, {1'b1, 15'h0200, 16'ha55a}, "byte pair");
      host.access(1'b0, 15'h0033, ~o[0], 16'h0000, 1'b1, r);
      chk(r, {2'b01, 16'h00cc}, "high lane");
      host.access(1'b0, 15'h0033, o[0], 16'h0000, 1'b1, r);
      chk(r, {2'b01, 16'h0033}, "low lane");
    end
    $display("done: byte8");
  endtask

  task automatic t_refuse;
    n_req = 0;
    host.access(1'b1, 15'h0300, 1'b0, 16'h1111, 1'b0, r);
    host.access(1'b0, 15'h0300, 1'b0, 16'h0000, 1'b0, r);
    chk(r[17:16], 2'b11, "bus idle");
    chk(n_req, 0, "no access");
    $display("done: refuse");
  endtask

  task automatic t_irq;
    level_irq_select = 1'b1;
    pulse(2'b11);
    chk({message_irq_n, general_irq_n}, 2'b00, "set");
    ack(3'b001, 8);
    chk(general_irq_n, 1'b0, "short ack");
    ack(3'b001, 30);
    chk(general_irq_n, 1'b1, "general ack");
    ack(3'b010, 30);
    chk(message_irq_n, 1'b1, "message ack");
    pulse(2'b01);
    host.access(1'b0, PENDING_IRQ_WADDR, 1'b0, 16'h0000, 1'b1, r);
    chk(general_irq_n, 1'b1, "pending read");
    combined_ack_variant = 1'b1;
    pulse(2'b11);
    ack(3'b100, 30);
    chk({message_irq_n, general_irq_n}, 2'b11, "combined ack");
    combined_ack_variant = 1'b0;
    level_irq_select = 1'b0;
    general_irq_ack = 1'b1;
    pulse(2'b01);
    chk(general_irq_n, 1'b0, "pulse low");
    @(posedge clk);
    #1 chk(general_irq_n, 1'b1, "pulse ends");
    general_irq_ack = 1'b0;
    $display("done: irq");
  endtask

  task automatic t_serial;
    logic [39:0] q;
    serial_variant = 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      byte_order_select = o[0];
      n_req = 0;
      host.spi_frame({24'h000210, o[0] ? 16'h1234 : 16'h3412}, q);
      chk(n_req, 1, "serial word");
      chk(last, {1'b1, 15'h0210, 16'h1234}, "serial write");
      host.spi_frame({24'h800021, 16'h0000}, q);
      chk(q[15:0], o[0] ? 16'hde21 : 16'h21de, "serial read");
    end
    chk(spi_so_oe_n, 1'b1, "serial released");
    $display("done: serial");
  endtask

  initial
  begin
    #40000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_ready();
    t_word16();
    t_byte8();
    t_refuse();
    t_irq();
    t_serial();
    give_verdict();
  end
endmodule
`default_nettype wire
